/* File: hw/alu_ops_pkg.sv */
// Shared constants, encodings and timing for the compare/divide/xor execution unit
package alu_ops_pkg;

  // ---------------------------------------------------------------------------
  // Data widths
  // ---------------------------------------------------------------------------
  localparam int DATA_W    = 24;
  localparam int SEL_W     = 2;
  localparam int RAMPTR_W  = 8;
  localparam int ADDR_W    = 4;
  localparam int CNT_W     = 5;
  localparam int FRAC_SHIFT = 24;

  // ---------------------------------------------------------------------------
  // Accumulator select codes: x, y, z, r
  // ---------------------------------------------------------------------------
  localparam logic [SEL_W-1:0] ACC_X = 2'h0;
  localparam logic [SEL_W-1:0] ACC_Y = 2'h1;
  localparam logic [SEL_W-1:0] ACC_Z = 2'h2;
  localparam logic [SEL_W-1:0] ACC_R = 2'h3;

  // ---------------------------------------------------------------------------
  // Flag bit positions in the flag register
  // ---------------------------------------------------------------------------
  localparam int FLAG_Z = 0;
  localparam int FLAG_S = 1;
  localparam int FLAG_O = 2;
  localparam int FLAG_C = 3;
  localparam int FLAG_W = 4;

  // ---------------------------------------------------------------------------
  // Register map (word index on the plain register port)
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_ACC_X  = 4'h0;
  localparam logic [ADDR_W-1:0] REG_ACC_Y  = 4'h1;
  localparam logic [ADDR_W-1:0] REG_ACC_Z  = 4'h2;
  localparam logic [ADDR_W-1:0] REG_ACC_R  = 4'h3;
  localparam logic [ADDR_W-1:0] REG_FLAGS  = 4'h4;
  localparam logic [ADDR_W-1:0] REG_RAMPTR = 4'h5;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h6;
  localparam int STATUS_BUSY = 0;
  localparam int STATUS_WDT  = 1;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [DATA_W-1:0]   ACC_RESET    = 24'h000000;
  localparam logic [3:0]          FLAGS_RESET  = 4'h0;
  localparam logic [RAMPTR_W-1:0] RAMPTR_RESET = 8'h00;

  // ---------------------------------------------------------------------------
  // Operation codes on the instruction port
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_CLEAR_WATCHDOG = 3'h0,
    OP_COMPARE        = 3'h1,
    OP_COMPLEMENT     = 3'h2,
    OP_DEC_RAMPTR     = 3'h3,
    OP_FRAC_DIVIDE    = 3'h4,
    OP_DIVMOD         = 3'h5,
    OP_XOR            = 3'h6
  } op_e;

  // ---------------------------------------------------------------------------
  // Execution length in cycles, and instruction size in bytes
  // ---------------------------------------------------------------------------
  localparam logic [CNT_W-1:0] CYC_CLRWDT    = 5'h02;
  localparam logic [CNT_W-1:0] CYC_CMP_REG   = 5'h01;
  localparam logic [CNT_W-1:0] CYC_CMP_IMM   = 5'h04;
  localparam logic [CNT_W-1:0] CYC_COMPL     = 5'h02;
  localparam logic [CNT_W-1:0] CYC_DECRAM    = 5'h01;
  localparam logic [CNT_W-1:0] CYC_DIV       = 5'h14;
  localparam logic [CNT_W-1:0] CYC_XOR_REG   = 5'h03;
  localparam logic [CNT_W-1:0] CYC_XOR_IMM   = 5'h06;

  localparam logic [2:0] BYTES_CLRWDT  = 3'h2;
  localparam logic [2:0] BYTES_CMP_REG = 3'h1;
  localparam logic [2:0] BYTES_CMP_IMM = 3'h4;
  localparam logic [2:0] BYTES_COMPL   = 3'h2;
  localparam logic [2:0] BYTES_DECRAM  = 3'h1;
  localparam logic [2:0] BYTES_DIV     = 3'h2;
  localparam logic [2:0] BYTES_XOR_REG = 3'h2;
  localparam logic [2:0] BYTES_XOR_IMM = 3'h5;

  // Quotient bits retired per divider cycle
  localparam int DIV_RADIX_BITS = 2;
  localparam int DIV_STEPS      = DATA_W / DIV_RADIX_BITS;

endpackage

/* File: hw/mag_divider.sv */
// Iterative unsigned divider, two quotient bits per clock
`timescale 1ns/1ps
module mag_divider
(
  // Clock and reset
  input  wire logic                              i_clk_sys,
  input  wire logic                              i_resetn,
  // Request
  input  wire logic                              i_start,
  input  wire logic [alu_ops_pkg::DATA_W-1:0]    i_rem_init,
  input  wire logic [alu_ops_pkg::DATA_W-1:0]    i_numer,
  input  wire logic [alu_ops_pkg::DATA_W-1:0]    i_denom,
  // Result
  output logic                                   o_done,
  output logic      [alu_ops_pkg::DATA_W-1:0]    o_quot,
  output logic      [alu_ops_pkg::DATA_W-1:0]    o_rem
);

  localparam int W = alu_ops_pkg::DATA_W;

  logic [W-1:0] rem_q,  rem_d;
  logic [W-1:0] quo_q,  quo_d;
  logic [W-1:0] den_q,  den_d;
  logic [4:0]   step_q, step_d;
  logic         run_q,  run_d;
  logic         done_q, done_d;

  // ---------------------------------------------------------------------------
  // Next state: restoring steps, quotient shifts in where numerator shifts out
  // ---------------------------------------------------------------------------
  always_comb
  begin
    logic [W:0]   trial;
    logic [W-1:0] r;
    logic [W-1:0] q;
    trial  = '0;
    r      = rem_q;
    q      = quo_q;
    rem_d  = rem_q;
    quo_d  = quo_q;
    den_d  = den_q;
    step_d = step_q;
    run_d  = run_q;
    done_d = 1'b0;
    if (i_start)
    begin
      rem_d  = i_rem_init;
      quo_d  = i_numer;
      den_d  = i_denom;
      step_d = 5'(alu_ops_pkg::DIV_STEPS);
      run_d  = 1'b1;
    end
    else if (run_q)
    begin
      for (int k = 0; k < alu_ops_pkg::DIV_RADIX_BITS; k++)
      begin
        trial = {r, q[W-1]} - {1'b0, den_q};
        if (!trial[W])
        begin
          r = trial[W-1:0];
          q = {q[W-2:0], 1'b1};
        end
        else
        begin
          r = {r[W-2:0], q[W-1]};
          q = {q[W-2:0], 1'b0};
        end
      end
      rem_d  = r;
      quo_d  = q;
      step_d = step_q - 5'h01;
      if (step_q == 5'h01)
      begin
        run_d  = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rem_q  <= '0;
      quo_q  <= '0;
      den_q  <= '0;
      step_q <= 5'h00;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      rem_q  <= rem_d;
      quo_q  <= quo_d;
      den_q  <= den_d;
      step_q <= step_d;
      run_q  <= run_d;
      done_q <= done_d;
    end
  end

  assign o_done = done_q;
  assign o_quot = quo_q;
  assign o_rem  = rem_q;

endmodule

/* File: hw/cpu_exec_unit.sv */
// Execution unit for watchdog clear, compare, complement, pointer decrement, divides and xor
//
// Overview of operation
// - Watchdog clear: two bytes, no operands, no flags, pulses watchdog restart.
// - Compare sets C, O, S, Z from p2 minus p1; registers unchanged.
// - Compare with 24-bit immediate takes four bytes and four cycles.
// - Complement negates the accumulator, sets S and Z, two bytes, two cycles.
// - Pointer decrement lowers RAM pointer by one, no flags, one cycle.
// - Fractional divide writes (p1 shifted left 24) / p2 to p1, sets S, Z.
// - Fractional divide is two bytes, twenty cycles, accumulator operands only; the code also takes i_imm as divisor when i_src_is_imm is set.
// - Divmod writes signed quotient to p1, remainder to p2, sets S, Z.
// - Xor writes p1 xor p2, sets S, Z; register form two bytes, three cycles.
// - Xor with 24-bit immediate takes five bytes and six cycles.
// - Destination is one of x, y, z, r; source accumulator or immediate.
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module cpu_exec_unit
(
  // Clock and reset
  input  wire logic                                i_clk_sys,
  input  wire logic                                i_resetn,
  // Instruction port
  input  wire logic                                i_op_valid,
  input  wire logic [2:0]                          i_opcode,
  input  wire logic [alu_ops_pkg::SEL_W-1:0]       i_accumulator_select,
  input  wire logic [alu_ops_pkg::SEL_W-1:0]       i_src_select,
  input  wire logic                                i_src_is_imm,
  input  wire logic [alu_ops_pkg::DATA_W-1:0]      i_imm,
  output logic                                     o_op_ready,
  output logic                                     o_op_done,
  output logic      [2:0]                          o_op_bytes,
  output logic                                     o_op_illegal,
  // Watchdog restart
  output logic                                     o_wdt_clear,
  // Register port
  input  wire logic [alu_ops_pkg::ADDR_W-1:0]      i_reg_addr,
  input  wire logic [31:0]                         i_reg_wdata,
  input  wire logic                                i_reg_wr,
  input  wire logic                                i_reg_rd,
  output logic      [31:0]                         o_reg_rdata,
  // Flags and pointer
  output logic      [3:0]                          o_carry_overflow_sign_zero_flags,
  output logic      [alu_ops_pkg::RAMPTR_W-1:0]    o_ram_ptr
);

  localparam int W = alu_ops_pkg::DATA_W;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } state_e;

  state_e                          state_q, state_d;
  logic [alu_ops_pkg::CNT_W-1:0]   cnt_q, cnt_d;
  alu_ops_pkg::op_e                op_q, op_d;
  logic [1:0]                      dst_q, dst_d;
  logic [1:0]                      srcsel_q, srcsel_d;
  logic [W-1:0]                    src_q, src_d;
  logic                            qneg_q, qneg_d;
  logic                            rneg_q, rneg_d;
  logic [2:0]                      bytes_q, bytes_d;
  logic                            done_q, done_d;
  logic                            wdt_q, wdt_d;
  logic                            illegal_q, illegal_d;
  logic                            wdt_seen_q, wdt_seen_d;
  logic [W-1:0]                    acc_q [4];
  logic [W-1:0]                    acc_d [4];
  logic [3:0]                      flags_q, flags_d;
  logic [alu_ops_pkg::RAMPTR_W-1:0] ptr_q, ptr_d;
  logic [31:0]                     rdata_q, rdata_d;

  logic                            accept;
  logic                            div_start;
  logic [W-1:0]                    opa, opb;
  logic [W-1:0]                    mag_a, mag_b;
  logic [W-1:0]                    div_rem_init, div_numer;
  logic                            div_done;
  logic [W-1:0]                    div_quot, div_rem;

  assign accept = i_op_valid && (state_q == ST_IDLE);

  // ---------------------------------------------------------------------------
  // Operand fetch: destination from the four accumulators, source from them or the immediate
  // ---------------------------------------------------------------------------
  // operand selection
  assign opa   = acc_q[i_accumulator_select];
  assign opb   = i_src_is_imm ? i_imm : acc_q[i_src_select];
  assign mag_a = opa[W-1] ? W'(-opa) : opa;
  assign mag_b = opb[W-1] ? W'(-opb) : opb;

  // fractional numerator: upper half already below divisor
  always_comb
  begin
    div_start    = accept && ((i_opcode == 3'(alu_ops_pkg::OP_FRAC_DIVIDE)) ||
                              (i_opcode == 3'(alu_ops_pkg::OP_DIVMOD)));
    div_rem_init = (i_opcode == 3'(alu_ops_pkg::OP_FRAC_DIVIDE)) ? mag_a : '0;
    div_numer    = (i_opcode == 3'(alu_ops_pkg::OP_FRAC_DIVIDE)) ? '0 : mag_a;
  end

  mag_divider u_div
  (
    .i_clk_sys  (i_clk_sys),
    .i_resetn   (i_resetn),
    .i_start    (div_start),
    .i_rem_init (div_rem_init),
    .i_numer    (div_numer),
    .i_denom    (mag_b),
    .o_done     (div_done),
    .o_quot     (div_quot),
    .o_rem      (div_rem)
  );

  // ---------------------------------------------------------------------------
  // Sequencer: capture, count down, commit on the last cycle
  // ---------------------------------------------------------------------------
  always_comb
  begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    op_d      = op_q;
    dst_d     = dst_q;
    srcsel_d  = srcsel_q;
    src_d     = src_q;
    qneg_d    = qneg_q;
    rneg_d    = rneg_q;
    bytes_d   = bytes_q;
    illegal_d = 1'b0;
    unique case (state_q)
      ST_IDLE:
      begin
        if (i_op_valid)
        begin
          dst_d    = i_accumulator_select;
          srcsel_d = i_src_select;
          src_d    = opb;
          qneg_d   = opa[W-1] ^ opb[W-1];
          rneg_d   = opa[W-1];
          state_d  = ST_RUN;
          case (i_opcode)
            3'(alu_ops_pkg::OP_CLEAR_WATCHDOG):
            begin
              op_d    = alu_ops_pkg::OP_CLEAR_WATCHDOG;
              cnt_d   = alu_ops_pkg::CYC_CLRWDT - 5'h01;
              bytes_d = alu_ops_pkg::BYTES_CLRWDT;
            end
            3'(alu_ops_pkg::OP_COMPARE):
            begin
              op_d    = alu_ops_pkg::OP_COMPARE;
              cnt_d   = (i_src_is_imm ? alu_ops_pkg::CYC_CMP_IMM : alu_ops_pkg::CYC_CMP_REG) - 5'h01;
              bytes_d = i_src_is_imm ? alu_ops_pkg::BYTES_CMP_IMM : alu_ops_pkg::BYTES_CMP_REG;
            end
            3'(alu_ops_pkg::OP_COMPLEMENT):
            begin
              op_d    = alu_ops_pkg::OP_COMPLEMENT;
              cnt_d   = alu_ops_pkg::CYC_COMPL - 5'h01;
              bytes_d = alu_ops_pkg::BYTES_COMPL;
            end
            3'(alu_ops_pkg::OP_DEC_RAMPTR):
            begin
              op_d    = alu_ops_pkg::OP_DEC_RAMPTR;
              cnt_d   = alu_ops_pkg::CYC_DECRAM - 5'h01;
              bytes_d = alu_ops_pkg::BYTES_DECRAM;
            end
            3'(alu_ops_pkg::OP_FRAC_DIVIDE), 3'(alu_ops_pkg::OP_DIVMOD):
            begin
              op_d    = alu_ops_pkg::op_e'(i_opcode);
              cnt_d   = alu_ops_pkg::CYC_DIV - 5'h01;
              bytes_d = alu_ops_pkg::BYTES_DIV;
            end
            3'(alu_ops_pkg::OP_XOR):
            begin
              op_d    = alu_ops_pkg::OP_XOR;
              cnt_d   = (i_src_is_imm ? alu_ops_pkg::CYC_XOR_IMM : alu_ops_pkg::CYC_XOR_REG) - 5'h01;
              bytes_d = i_src_is_imm ? alu_ops_pkg::BYTES_XOR_IMM : alu_ops_pkg::BYTES_XOR_REG;
            end
            default:
            begin
              // Unknown code: flagged and dropped, unit stays free
              state_d   = ST_IDLE;
              illegal_d = 1'b1;
            end
          endcase
        end
      end
      ST_RUN:
      begin
        if (cnt_q == 5'h00)
          state_d = ST_IDLE;
        else
          cnt_d = cnt_q - 5'h01;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Commit of results, flags and pointer; register port writes
  // ---------------------------------------------------------------------------
  always_comb
  begin
    logic [W:0]   diff;
    logic [W-1:0] res;
    logic [W-1:0] a;
    logic         commit;
    for (int i = 0; i < 4; i++)
      acc_d[i] = acc_q[i];
    flags_d    = flags_q;
    ptr_d      = ptr_q;
    done_d     = 1'b0;
    wdt_d      = 1'b0;
    wdt_seen_d = wdt_seen_q;
    a          = acc_q[dst_q];
    diff       = '0;
    res        = '0;
    commit     = (state_q == ST_RUN) && (cnt_q == 5'h00);
    // Software writes are ignored while an instruction is in flight
    if (i_reg_wr && (state_q == ST_IDLE))
    begin
      unique case (i_reg_addr)
        alu_ops_pkg::REG_ACC_X, alu_ops_pkg::REG_ACC_Y,
        alu_ops_pkg::REG_ACC_Z, alu_ops_pkg::REG_ACC_R:
          acc_d[i_reg_addr[1:0]] = i_reg_wdata[W-1:0];
        alu_ops_pkg::REG_FLAGS:
          flags_d = i_reg_wdata[3:0];
        alu_ops_pkg::REG_RAMPTR:
          ptr_d = i_reg_wdata[alu_ops_pkg::RAMPTR_W-1:0];
        alu_ops_pkg::REG_STATUS:
          if (i_reg_wdata[alu_ops_pkg::STATUS_WDT])
            wdt_seen_d = 1'b0;
        default:
        begin
        end
      endcase
    end
    if (commit)
    begin
      done_d = 1'b1;
      unique case (op_q)
        alu_ops_pkg::OP_CLEAR_WATCHDOG:
        begin
          wdt_d      = 1'b1;
          wdt_seen_d = 1'b1;
        end
        alu_ops_pkg::OP_COMPARE:
        begin
          diff = {1'b0, src_q} - {1'b0, a};
          res  = diff[W-1:0];
          flags_d[alu_ops_pkg::FLAG_C] = diff[W];
          flags_d[alu_ops_pkg::FLAG_O] = (src_q[W-1] ^ a[W-1]) & (src_q[W-1] ^ res[W-1]);
        end
        alu_ops_pkg::OP_COMPLEMENT:
        begin
          res = ~a + 24'h000001;
          acc_d[dst_q] = res;
        end
        alu_ops_pkg::OP_DEC_RAMPTR:
          ptr_d = ptr_q - 8'h01;
        alu_ops_pkg::OP_FRAC_DIVIDE:
        begin
          res = qneg_q ? W'(-div_quot) : div_quot;
          acc_d[dst_q] = res;
        end
        alu_ops_pkg::OP_DIVMOD:
        begin
          // quotient to p1, remainder to p2
          res = qneg_q ? W'(-div_quot) : div_quot;
          acc_d[srcsel_q] = rneg_q ? W'(-div_rem) : div_rem;
          acc_d[dst_q]    = res;
        end
        alu_ops_pkg::OP_XOR:
        begin
          res = a ^ src_q;
          acc_d[dst_q] = res;
        end
      endcase
      if ((op_q != alu_ops_pkg::OP_CLEAR_WATCHDOG) && (op_q != alu_ops_pkg::OP_DEC_RAMPTR))
      begin
        flags_d[alu_ops_pkg::FLAG_S] = res[W-1];
        flags_d[alu_ops_pkg::FLAG_Z] = (res == '0);
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Register port read: data stands the cycle after the strobe
  // ---------------------------------------------------------------------------
  always_comb
  begin
    rdata_d = 32'h00000000;
    if (i_reg_rd)
    begin
      unique case (i_reg_addr)
        alu_ops_pkg::REG_ACC_X, alu_ops_pkg::REG_ACC_Y,
        alu_ops_pkg::REG_ACC_Z, alu_ops_pkg::REG_ACC_R:
          rdata_d[W-1:0] = acc_q[i_reg_addr[1:0]];
        alu_ops_pkg::REG_FLAGS:
          rdata_d[3:0] = flags_q;
        alu_ops_pkg::REG_RAMPTR:
          rdata_d[alu_ops_pkg::RAMPTR_W-1:0] = ptr_q;
        alu_ops_pkg::REG_STATUS:
        begin
          rdata_d[alu_ops_pkg::STATUS_BUSY] = (state_q == ST_RUN);
          rdata_d[alu_ops_pkg::STATUS_WDT]  = wdt_seen_q;
        end
        default:
          rdata_d = 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_q    <= ST_IDLE;
      cnt_q      <= 5'h00;
      op_q       <= alu_ops_pkg::OP_CLEAR_WATCHDOG;
      dst_q      <= 2'h0;
      srcsel_q   <= 2'h0;
      src_q      <= '0;
      qneg_q     <= 1'b0;
      rneg_q     <= 1'b0;
      bytes_q    <= 3'h0;
      done_q     <= 1'b0;
      wdt_q      <= 1'b0;
      illegal_q  <= 1'b0;
      wdt_seen_q <= 1'b0;
      flags_q    <= alu_ops_pkg::FLAGS_RESET;
      ptr_q      <= alu_ops_pkg::RAMPTR_RESET;
      rdata_q    <= 32'h00000000;
      for (int i = 0; i < 4; i++)
        acc_q[i] <= alu_ops_pkg::ACC_RESET;
    end
    else
    begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      op_q       <= op_d;
      dst_q      <= dst_d;
      srcsel_q   <= srcsel_d;
      src_q      <= src_d;
      qneg_q     <= qneg_d;
      rneg_q     <= rneg_d;
      bytes_q    <= bytes_d;
      done_q     <= done_d;
      wdt_q      <= wdt_d;
      illegal_q  <= illegal_d;
      wdt_seen_q <= wdt_seen_d;
      flags_q    <= flags_d;
      ptr_q      <= ptr_d;
      rdata_q    <= rdata_d;
      for (int i = 0; i < 4; i++)
        acc_q[i] <= acc_d[i];
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign o_op_ready   = (state_q == ST_IDLE);
  assign o_op_done    = done_q;
  assign o_op_bytes   = bytes_q;
  assign o_op_illegal = illegal_q;
  assign o_wdt_clear  = wdt_q;
  assign o_reg_rdata  = rdata_q;
  assign o_ram_ptr    = ptr_q;
  assign o_carry_overflow_sign_zero_flags = flags_q;

endmodule

/* File: verification/cpu_exec_unit_assertions.sv */
// Concurrent timing and flag checks for the execution unit
`timescale 1ns/1ps
module cpu_exec_unit_assertions
(
  // Watched ports
  input  wire logic                             i_clk_sys,
  input  wire logic                             i_resetn,
  input  wire logic                             i_op_valid,
  input  wire logic [2:0]                       i_opcode,
  input  wire logic                             i_src_is_imm,
  input  wire logic                             o_op_ready,
  input  wire logic                             o_op_done,
  input  wire logic                             o_wdt_clear,
  input  wire logic [3:0]                       o_carry_overflow_sign_zero_flags,
  input  wire logic [alu_ops_pkg::RAMPTR_W-1:0] o_ram_ptr
);
  // ---------------------------------------------------------------------------
  // Accept strobe and per-opcode latency
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  logic [3:0] fl;
  logic       go;
  assign fl = o_carry_overflow_sign_zero_flags;
  assign go = i_op_valid && o_op_ready;

  AST_CMP_REG: assert property (go && i_opcode == 3'h1 && !i_src_is_imm |->
    ##1 !o_op_ready ##1 (o_op_done && o_op_ready)) else $error("cmp reg timing");
  AST_CMP_IMM: assert property (go && i_opcode == 3'h1 && i_src_is_imm |->
    ##1 !o_op_ready[*4] ##1 o_op_done) else $error("cmp imm timing");
  AST_COMPL_KEEPS_CO: assert property (go && i_opcode == 3'h2 |->
    ##1 !o_op_ready[*2] ##1 (o_op_done && ((fl ^ $past(fl, 3)) & 4'hc) == 4'h0)) else $error("complement wrong");
  AST_PTR_DEC: assert property (go && i_opcode == 3'h3 |->
    ##2 (o_op_done && o_ram_ptr == $past(o_ram_ptr, 2) - 8'h01 && $stable(fl))) else $error("pointer step wrong");
  AST_WDT_PULSE: assert property (go && i_opcode == 3'h0 |->
    ##1 !o_wdt_clear[*2] ##1 (o_wdt_clear && $stable(fl))) else $error("wdt restart wrong");
  AST_FRAC_DIV: assert property (go && i_opcode == 3'h4 |->
    ##20 !o_op_ready ##1 o_op_done) else $error("div timing wrong");
  AST_DIVMOD_HOLD: assert property (go && i_opcode == 3'h5 |->
    ##1 !o_op_done[*8] ##13 (o_op_done && o_op_ready)) else $error("divmod hold wrong");
  AST_XOR_REG: assert property (go && i_opcode == 3'h6 && !i_src_is_imm |->
    ##1 !o_op_ready[*3] ##1 o_op_done) else $error("xor reg timing");
  AST_XOR_IMM: assert property (go && i_opcode == 3'h6 && i_src_is_imm |->
    ##1 !o_op_ready[*6] ##1 o_op_done) else $error("xor imm timing");
endmodule

bind cpu_exec_unit cpu_exec_unit_assertions chk (.i_clk_sys, .i_resetn, .i_op_valid, .i_opcode, .i_src_is_imm,
  .o_op_ready, .o_op_done, .o_wdt_clear, .o_carry_overflow_sign_zero_flags, .o_ram_ptr);

/* File: verification/cpu_exec_unit_test.sv */
// Self-checking bench for the execution unit
`timescale 1ns/1ps
module cpu_exec_unit_test;
  // ---------------------------------------------------------------------------
  // Signals and unit under test
  // ---------------------------------------------------------------------------
  logic        i_clk_sys = 1'b0;
  logic        i_resetn = 1'b0;
  logic        i_op_valid = 1'b0;
  logic [2:0]  i_opcode = 3'h0;
  logic [1:0]  i_accumulator_select = 2'h0;
  logic [1:0]  i_src_select = 2'h0;
  logic        i_src_is_imm = 1'b0;
  logic [23:0] i_imm = 24'h0;
  logic [3:0]  i_reg_addr = 4'h0;
  logic [31:0] i_reg_wdata = 32'h0;
  logic        i_reg_wr = 1'b0;
  logic        i_reg_rd = 1'b0;
  logic        o_op_ready, o_op_done, o_op_illegal, o_wdt_clear;
  logic [2:0]  o_op_bytes;
  logic [31:0] o_reg_rdata;
  logic [3:0]  o_carry_overflow_sign_zero_flags;
  logic [7:0]  o_ram_ptr;
  wire  [31:0] fl = {28'h0, o_carry_overflow_sign_zero_flags};
  int          error_cnt = 0;
  int          n_compared = 0;
  always #25 i_clk_sys = ~i_clk_sys;
  cpu_exec_unit uut (.i_clk_sys, .i_resetn, .i_op_valid, .i_opcode, .i_accumulator_select, .i_src_select,
    .i_src_is_imm, .i_imm, .o_op_ready, .o_op_done, .o_op_bytes, .o_op_illegal, .o_wdt_clear, .i_reg_addr,
    .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_carry_overflow_sign_zero_flags, .o_ram_ptr);
  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Borrow as carry, signed overflow of p2 - p1
  function automatic logic [31:0] cmpf(input logic [23:0] a, input logic [23:0] b);
    logic [24:0] d;
    d = {1'b0, b} - {1'b0, a};
    return {28'h0, d[24], a[23] != b[23] && d[23] != b[23], d[23], d[23:0] == 24'h0};
  endfunction
  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= {8'h00, d};
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rc(input string nm, input logic [3:0] a, input logic [31:0] e);
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b0;
    @(posedge i_clk_sys);
    chk(nm, e, o_reg_rdata);
  endtask
  // Ends at the edge that samples the done or illegal pulse; counts edges after the accept edge
  task automatic run(input logic [2:0] op, input logic [1:0] d, input logic [1:0] s, input logic im,
                     input logic [23:0] k, input int n, input logic [2:0] nb);
    int c;
    c = 0;
    @(posedge i_clk_sys);
    i_op_valid <= 1'b1;
    i_opcode <= op;
    i_accumulator_select <= d;
    i_src_select <= s;
    i_src_is_imm <= im;
    i_imm <= k;
    @(posedge i_clk_sys);
    i_op_valid <= 1'b0;
    do
    begin
      @(posedge i_clk_sys);
      c++;
    end
    while ((o_op_done | o_op_illegal) !== 1'b1 && c < 40);
    chk("cycles", 32'(n + 1), 32'(c));
    chk("bytes", {29'h0, nb}, {29'h0, o_op_bytes});
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    rc("flags", 4'h4, 32'h0);
    rc("ramptr", 4'h5, 32'h0);
    rc("unmapped", 4'h9, 32'h0);
  endtask
  task automatic t_xor;
    wr(4'h0, 24'h5a5a5a);
    wr(4'h1, 24'hff00f0);
    run(3'h6, 2'h0, 2'h1, 1'b0, 24'h0, 3, 3'h2);
    chk("xor flags", 32'h2, fl);
    rc("xor reg", 4'h0, 32'ha55aaa);
    run(3'h6, 2'h0, 2'h0, 1'b1, 24'ha55aaa, 6, 3'h5);
    chk("xor imm flags", 32'h1, fl);
    rc("xor imm", 4'h0, 32'h0);
  endtask
  task automatic t_cmp;
    wr(4'h0, 24'h7fffff);
    wr(4'h1, 24'h800000);
    run(3'h1, 2'h0, 2'h1, 1'b0, 24'h0, 1, 3'h1);
    chk("cmp flags", cmpf(24'h7fffff, 24'h800000), fl);
    rc("cmp p1", 4'h0, 32'h7fffff);
    rc("cmp p2", 4'h1, 32'h800000);
    run(3'h1, 2'h0, 2'h0, 1'b1, 24'h0, 4, 3'h4);
    chk("cmp imm flags", cmpf(24'h7fffff, 24'h0), fl);
  endtask
  task automatic t_compl;
    wr(4'h4, 24'hc);
    for (int i = 0; i < 4; i++)
    begin
      wr(4'(i), 24'(i + 1));
      run(3'h2, 2'(i), 2'h0, 1'b0, 24'h0, 2, 3'h2);
      chk("compl flags", 32'he, fl);
      rc("compl", 4'(i), {8'h00, 24'(-(i + 1))});
    end
  endtask
  task automatic t_misc;
    run(3'h3, 2'h0, 2'h0, 1'b0, 24'h0, 1, 3'h1);
    chk("ptr wrap", 32'hff, {24'h0, o_ram_ptr});
    chk("ptr flags", 32'he, fl);
    run(3'h7, 2'h0, 2'h0, 1'b0, 24'h0, 0, 3'h1);
    run(3'h0, 2'h0, 2'h0, 1'b0, 24'h0, 2, 3'h2);
    chk("wdt flags", 32'he, fl);
    rc("wdt status", 4'h6, 32'h2);
  endtask
  task automatic t_div;
    wr(4'h2, 24'h100000);
    wr(4'h3, 24'h400000);
    run(3'h4, 2'h2, 2'h3, 1'b0, 24'h0, 20, 3'h2);
    chk("frac flags", 32'hc, fl);
    rc("frac", 4'h2, 32'h400000);
    wr(4'h1, 24'hfffff9);
    wr(4'h3, 24'h000002);
    run(3'h5, 2'h1, 2'h3, 1'b0, 24'h0, 20, 3'h2);
    chk("divmod flags", 32'he, fl);
    rc("quotient", 4'h1, 32'hfffffd);
    rc("remainder", 4'h3, 32'hffffff);
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    t_reset();
    t_xor();
    t_cmp();
    t_compl();
    t_div();
    t_misc();
    close_out();
  end
  // Whole sequence needs under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge i_clk_sys);
    error_cnt++;
    close_out();
  end
endmodule
